// ===== core/port_pkg.sv
/*
 * constants for the eight-pin port: register indices, byte addresses,
 * reset values and timer mode/counter-clear codes.
 * assumes a 32-bit apb bus with an 18-bit byte address.
 */
package port_pkg;
    localparam int          ADDR_W        = 18;
    localparam int          DATA_W        = 32;
    localparam int          PINS          = 8;
    localparam int          PAIRS         = 4;
    // printed offsets are not word aligned: they are indices
    localparam logic [15:0] IDX_PIN_DIRECTION  = 16'hFEB1;
    localparam logic [15:0] IDX_PIN_STATE      = 16'hFF51;
    localparam logic [15:0] IDX_OUTPUT_LATCH   = 16'hFF61;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION = {IDX_PIN_DIRECTION, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PIN_STATE     = {IDX_PIN_STATE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_OUTPUT_LATCH  = {IDX_OUTPUT_LATCH, 2'b00};
    localparam logic [7:0]  RST_PIN_DIRECTION  = 8'h00;
    localparam logic [7:0]  RST_OUTPUT_LATCH   = 8'h00;
    localparam logic [7:0]  DIR_READ_VALUE     = 8'h00;
    // timer mode field codes
    localparam logic [3:0]  MODE_NORMAL   = 4'h0;
    localparam logic [3:0]  MODE_PWM1     = 4'h2;
    localparam logic [3:0]  MODE_PWM2     = 4'h3;
    localparam logic [1:0]  MODE_PHASE_HI = 2'h1;
    // counter-clear codes naming each pin's own compare register
    localparam logic [2:0]  CCLR_CH3_A    = 3'h1;
    localparam logic [2:0]  CCLR_CH3_B    = 3'h2;
    localparam logic [2:0]  CCLR_CH3_C    = 3'h5;
    localparam logic [2:0]  CCLR_CH3_D    = 3'h6;
    localparam logic [2:0]  CCLR_2B_A     = 3'h1;
    localparam logic [2:0]  CCLR_2B_B     = 3'h2;
endpackage

// ===== core/pin_sync.sv
/*
 * two-flop synchroniser for the eight pin levels.
 * assumes pins are asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] d,
    output logic      [7:0] q
);
    logic [7:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 8'h00;
            q    <= 8'h00;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== core/pin_pair_func.sv
/*
 * timer function decode for one pin pair (a/b or c/d) of a channel.
 * assumes all settings come from timer logic on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_pair_func (
    input  wire logic [3:0] mode,
    input  wire logic [3:0] io_first,
    input  wire logic [3:0] io_second,
    input  wire logic [2:0] cclr,
    input  wire logic [2:0] clr_first,
    input  wire logic [2:0] clr_second,
    input  wire logic       phase_ok,
    input  wire logic       blocked,
    output logic      [1:0] own,
    output logic      [1:0] cap
);
    import port_pkg::*;

    logic normal;
    logic pwm1;
    logic pwm2;
    logic oc_first;
    logic oc_second;
    logic act_first;
    logic act_second;

    always_comb begin
        normal     = (mode == MODE_NORMAL) || (phase_ok && mode[3:2] == MODE_PHASE_HI);
        pwm1       = (mode == MODE_PWM1);
        pwm2       = (mode == MODE_PWM2);
        oc_first   = !io_first[3] && (io_first[1:0] != 2'h0);
        oc_second  = !io_second[3] && (io_second[1:0] != 2'h0);
        act_first  = (io_first[1:0] != 2'h0);
        act_second = (io_second[1:0] != 2'h0);
        own[0] = (normal && oc_first) || (pwm1 && act_first)
               || (pwm2 && act_first && cclr != clr_first);
        own[1] = (normal && oc_second) || (pwm2 && act_second && cclr != clr_second);
        if (blocked) begin
            own = 2'b00;
        end
        cap[0] = normal && io_first[3];
        cap[1] = normal && io_second[3];
    end
endmodule
`default_nettype wire

// ===== core/gpio_port.sv
/*
 * eight-pin general-purpose port with timer and pattern sharing,
 * apb register slave, per-pin function multiplexer.
 * assumes timer and pattern signals are on pclk; pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module gpio_port
    import port_pkg::*;
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [port_pkg::ADDR_W-1:0] paddr,
    input  wire logic [port_pkg::DATA_W-1:0] pwdata,
    output logic      [port_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        hw_standby,
    input  wire logic                        sw_standby,
    input  wire logic [3:0]                  timer_mode_field_3,
    input  wire logic [3:0]                  timer_mode_field_4,
    input  wire logic [3:0]                  timer_mode_field_5,
    input  wire logic [31:0]                 io_control_field,
    input  wire logic [2:0]                  counter_clear_select_3,
    input  wire logic [1:0]                  counter_clear_select_4,
    input  wire logic [1:0]                  counter_clear_select_5,
    input  wire logic                        buffer_mode_a,
    input  wire logic                        buffer_mode_b,
    input  wire logic [7:0]                  timer_compare_out,
    input  wire logic [7:0]                  pattern_out_bit,
    input  wire logic [7:0]                  pattern_enable_bit,
    input  wire logic [7:0]                  pin_in,
    output logic      [7:0]                  pin_out,
    output logic      [7:0]                  pin_oe,
    output logic      [7:0]                  timer_capture_in,
    output logic      [7:0]                  timer_capture_en
);
    import port_pkg::*;

    typedef struct packed {
        logic [7:0]        pin_direction;
        logic [7:0]        output_latch;
        logic [7:0]        pin_state;
        logic [7:0]        pin_out;
        logic [7:0]        pin_oe;
        logic [7:0]        cap_in;
        logic [7:0]        cap_en;
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;
    logic [7:0]  pin_level;
    logic [7:0]  timer_own;
    logic [7:0]  timer_cap;
    logic [3:0]  pair_mode [PAIRS];
    logic [2:0]  pair_cclr [PAIRS];
    logic [2:0]  pair_clr_a [PAIRS];
    logic [2:0]  pair_clr_b [PAIRS];
    logic        setup;
    logic        access;
    logic        hit_dir;
    logic        hit_state;
    logic        hit_latch;
    logic [7:0]  view;

    pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pin_in),
        .q       (pin_level)
    );

    always_comb begin
        pair_mode[0]  = timer_mode_field_3;
        pair_mode[1]  = timer_mode_field_3;
        pair_mode[2]  = timer_mode_field_4;
        pair_mode[3]  = timer_mode_field_5;
        pair_cclr[0]  = counter_clear_select_3;
        pair_cclr[1]  = counter_clear_select_3;
        pair_cclr[2]  = {1'b0, counter_clear_select_4};
        pair_cclr[3]  = {1'b0, counter_clear_select_5};
        pair_clr_a[0] = CCLR_CH3_A;
        pair_clr_b[0] = CCLR_CH3_B;
        pair_clr_a[1] = CCLR_CH3_C;
        pair_clr_b[1] = CCLR_CH3_D;
        pair_clr_a[2] = CCLR_2B_A;
        pair_clr_b[2] = CCLR_2B_B;
        pair_clr_a[3] = CCLR_2B_A;
        pair_clr_b[3] = CCLR_2B_B;
    end

    genvar g;
    generate
        for (g = 0; g < PAIRS; g++) begin : gen_pair
            pin_pair_func u_func (
                .mode       (pair_mode[g]),
                .io_first   (io_control_field[8*g+3 -: 4]),
                .io_second  (io_control_field[8*g+7 -: 4]),
                .cclr       (pair_cclr[g]),
                .clr_first  (pair_clr_a[g]),
                .clr_second (pair_clr_b[g]),
                .phase_ok   (g >= 2),
                .blocked    ((g == 1) && (buffer_mode_a || buffer_mode_b)),
                .own        (timer_own[2*g+1 -: 2]),
                .cap        (timer_cap[2*g+1 -: 2])
            );
        end
    endgenerate

    always_comb begin
        setup     = psel && !penable;
        access    = psel && penable && state.pready;
        hit_dir   = (paddr == ADDR_PIN_DIRECTION);
        hit_state = (paddr == ADDR_PIN_STATE);
        hit_latch = (paddr == ADDR_OUTPUT_LATCH);
        view      = (state.pin_direction & state.output_latch)
                  | (~state.pin_direction & pin_level);
    end

    always_comb begin
        next_state = state;
        // bus: answer in the first access cycle
        if (setup) begin
            next_state.pready  = 1'b1;
            next_state.pslverr = !(hit_dir || hit_state || hit_latch);
            next_state.prdata  = '0;
            if (!pwrite) begin
                if (hit_state) begin
                    next_state.prdata[7:0] = state.pin_state;
                end else if (hit_latch) begin
                    next_state.prdata[7:0] = state.output_latch;
                end else begin
                    next_state.prdata[7:0] = DIR_READ_VALUE;
                end
            end
        end else if (access) begin
            next_state.pready  = 1'b0;
            next_state.pslverr = 1'b0;
        end
        if (access && pwrite && hit_dir) begin
            next_state.pin_direction = pwdata[7:0];
        end
        if (access && pwrite && hit_latch) begin
            next_state.output_latch = pwdata[7:0];
        end
        if (hw_standby) begin
            next_state.pin_direction = RST_PIN_DIRECTION;
            next_state.output_latch  = RST_OUTPUT_LATCH;
        end
        if (!sw_standby) begin
            next_state.pin_state = view;
        end
        for (int i = 0; i < PINS; i++) begin
            if (timer_own[i]) begin
                next_state.pin_oe[i]  = 1'b1;
                next_state.pin_out[i] = timer_compare_out[i];
            end else if (state.pin_direction[i]) begin
                next_state.pin_oe[i]  = 1'b1;
                next_state.pin_out[i] = pattern_enable_bit[i] ? pattern_out_bit[i]
                                                              : state.output_latch[i];
            end else begin
                next_state.pin_oe[i]  = 1'b0;
                next_state.pin_out[i] = 1'b0;
            end
        end
        next_state.cap_en = timer_cap;
        next_state.cap_in = pin_level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state               <= '0;
            state.pin_direction <= RST_PIN_DIRECTION;
            state.output_latch  <= RST_OUTPUT_LATCH;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        prdata           = state.prdata;
        pready           = state.pready;
        pslverr          = state.pslverr;
        pin_out          = state.pin_out;
        pin_oe           = state.pin_oe;
        timer_capture_in = state.cap_in;
        timer_capture_en = state.cap_en;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_dir_drive;
        (access && pwrite && hit_dir && !hw_standby) |-> ##2
            ((pin_oe | $past(timer_own)) == ($past(pwdata[7:0], 2) | $past(timer_own)));
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("direction write not on pins");

    property p_dir_read;
        (access && !pwrite && hit_dir) |-> (prdata == '0);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read leaked");

    property p_standby_clear;
        hw_standby |=> (state.pin_direction == 8'h00) && (state.output_latch == 8'h00);
    endproperty
    a_standby_clear: assert property (p_standby_clear) else $error("standby clear failed");

    property p_latch_write;
        (access && pwrite && hit_latch && !hw_standby) |=>
            (state.output_latch == $past(pwdata[7:0]));
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost");

    property p_state_nowrite;
        (access && pwrite && hit_state && !hw_standby) |=>
            $stable(state.pin_direction) && $stable(state.output_latch);
    endproperty
    a_state_nowrite: assert property (p_state_nowrite) else $error("pin-state write acted");

    property p_state_read;
        (access && !pwrite && hit_state) |-> (prdata[7:0] == $past(state.pin_state));
    endproperty
    a_state_read: assert property (p_state_read) else $error("pin-state read wrong");

    property p_sw_hold;
        sw_standby |=> (state.pin_state == $past(state.pin_state));
    endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("pin-state moved in standby");

    property p_timer_first;
        ##1 (((pin_out ^ $past(timer_compare_out)) & $past(timer_own)) == 8'h00);
    endproperty
    a_timer_first: assert property (p_timer_first) else $error("timer output lost");

    property p_pattern;
        ##1 (((pin_out ^ $past(pattern_out_bit)) & $past(~timer_own & state.pin_direction
            & pattern_enable_bit)) == 8'h00);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern output wrong");

    property p_pwm1_pair;
        (timer_mode_field_3 == MODE_PWM1) |=> (pin_oe[1] == $past(state.pin_direction[1]));
    endproperty
    a_pwm1_pair: assert property (p_pwm1_pair) else $error("paired pin driven");

    property p_buffer;
        (buffer_mode_a || buffer_mode_b) |=> (pin_oe[3:2] == $past(state.pin_direction[3:2]));
    endproperty
    a_buffer: assert property (p_buffer) else $error("buffered pins driven");

    property p_answer;
        setup |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("apb answer timing");

    c_dir_write: cover property (access && pwrite && hit_dir);
    c_state_read: cover property (access && !pwrite && hit_state);
    c_pwm2_out: cover property ((timer_mode_field_3 == MODE_PWM2) && timer_own[0]);
endmodule
`default_nettype wire

// ===== test/pin_board.sv
/*
 * board model for the eight port pins.
 * assumes pin_out and pin_oe come from the port, board drive from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] board,
    output logic      [7:0] pin_in
);
    // a pin driven by the port shows its level, otherwise the board level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
/*
 * self-checking bench for the eight-pin port: apb registers, standby,
 * pin multiplexer for latch, pattern and timer functions.
 * assumes port_pkg, gpio_port and pin_board are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import port_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, io_control_field = '0, rd;
    logic        pready, pslverr, er, hw_standby = 0, sw_standby = 0;
    logic        buffer_mode_a = 0, buffer_mode_b = 0;
    logic [3:0]  timer_mode_field_3 = '0, timer_mode_field_4 = '0, timer_mode_field_5 = '0;
    logic [2:0]  counter_clear_select_3 = '0;
    logic [1:0]  counter_clear_select_4 = '0, counter_clear_select_5 = '0;
    logic [7:0]  timer_compare_out = '0, pattern_out_bit = '0, pattern_enable_bit = '0;
    logic [7:0]  pin_in, pin_out, pin_oe, timer_capture_in, timer_capture_en, board = '0;
    int          bad_count = 0, comparisons = 0;

    gpio_port gpio_port_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .hw_standby, .sw_standby, .timer_mode_field_3,
        .timer_mode_field_4, .timer_mode_field_5, .io_control_field,
        .counter_clear_select_3, .counter_clear_select_4, .counter_clear_select_5,
        .buffer_mode_a, .buffer_mode_b, .timer_compare_out, .pattern_out_bit,
        .pattern_enable_bit, .pin_in, .pin_out, .pin_oe, .timer_capture_in,
        .timer_capture_en
    );
    pin_board pin_board_i (.pin_out, .pin_oe, .board, .pin_in);

    always #4 pclk = ~pclk;

    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer, request held until pready is sampled high or 20 more cycles pass
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin
            bad_count++;
            $display("[FAIL] %0t no apb answer", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task t_reset;
        apb(0, ADDR_OUTPUT_LATCH, 0);
        chk(rd, 32'h0);
        apb(0, ADDR_PIN_DIRECTION, 0);
        chk(rd, 32'(DIR_READ_VALUE));
        chk(32'(pin_oe), 32'h0);
    endtask

    task t_port;
        board <= 8'hC3;
        apb(1, ADDR_OUTPUT_LATCH, 32'hA5);
        apb(1, ADDR_PIN_DIRECTION, 32'h0F);
        wt(2);
        chk(32'(pin_oe), 32'h0F);
        chk(32'(pin_out[3:0]), 32'h5);
        apb(0, ADDR_PIN_DIRECTION, 0);
        chk(rd, 32'(DIR_READ_VALUE));
        wt(6);
        apb(0, ADDR_PIN_STATE, 0);
        chk(rd, 32'hC5);
        apb(0, ADDR_OUTPUT_LATCH, 0);
        chk(rd, 32'hA5);
    endtask

    task t_refuse;
        apb(1, ADDR_PIN_STATE, 32'hFF);
        chk(32'(er), 32'h0);
        apb(0, ADDR_OUTPUT_LATCH, 0);
        chk(rd, 32'hA5);
        apb(0, ADDR_PIN_STATE, 0);
        chk(rd, 32'hC5);
        apb(1, 18'h00100, 32'hFF);
        chk(32'(er), 32'h1);
        apb(0, ADDR_OUTPUT_LATCH, 0);
        chk(rd, 32'hA5);
    endtask

    task t_standby;
        sw_standby <= 1'b1;
        wt(2);
        board <= 8'h3C;
        wt(8);
        apb(0, ADDR_PIN_STATE, 0);
        chk(rd, 32'hC5);
        chk(32'(pin_oe), 32'h0F);
        sw_standby <= 1'b0;
        wt(8);
        apb(0, ADDR_PIN_STATE, 0);
        chk(rd, 32'h35);
        hw_standby <= 1'b1;
        wt(2);
        hw_standby <= 1'b0;
        wt(2);
        chk(32'(pin_oe), 32'h0);
        apb(0, ADDR_OUTPUT_LATCH, 0);
        chk(rd, 32'h0);
        wt(6);
        apb(0, ADDR_PIN_STATE, 0);
        chk(rd, 32'h3C);
    endtask

    task t_pattern;
        apb(1, ADDR_OUTPUT_LATCH, 32'h05);
        apb(1, ADDR_PIN_DIRECTION, 32'hFF);
        pattern_enable_bit <= 8'hF0;
        pattern_out_bit <= 8'hA0;
        wt(3);
        chk(32'(pin_out), 32'hA5);
        pattern_enable_bit <= 8'h00;
        apb(1, ADDR_PIN_DIRECTION, 32'h00);
    endtask

    task tcase(input logic [3:0] m3, input logic [3:0] m45, input logic [31:0] io,
               input logic [7:0] oe);
        timer_mode_field_3 <= m3;
        timer_mode_field_4 <= m45;
        timer_mode_field_5 <= m45;
        io_control_field <= io;
        wt(3);
        chk(32'(pin_oe), 32'(oe));
    endtask

    task t_timer;
        timer_compare_out <= 8'h5A;
        tcase(4'h0, 4'h0, 32'h11111111, 8'hFF);
        chk(32'(pin_out), 32'h5A);
        tcase(4'h0, 4'h0, 32'h77777777, 8'hFF);
        tcase(4'h0, 4'h0, 32'h44444444, 8'h00);
        tcase(4'h0, 4'h0, 32'h88888888, 8'h00);
        chk(32'(timer_capture_en), 32'hFF);
        chk(32'(timer_capture_in), 32'h3C);
        tcase(4'h4, 4'h4, 32'h11111111, 8'hF0);
        tcase(4'h2, 4'h2, 32'h11111111, 8'h55);
        counter_clear_select_3 <= CCLR_CH3_A;
        counter_clear_select_4 <= 2'h2;
        counter_clear_select_5 <= 2'h2;
        tcase(4'h3, 4'h3, 32'h11111111, 8'h5E);
        buffer_mode_a <= 1'b1;
        tcase(4'h0, 4'h0, 32'h11111111, 8'hF3);
        buffer_mode_a <= 1'b0;
        buffer_mode_b <= 1'b1;
        tcase(4'h0, 4'h0, 32'h11111111, 8'hF3);
    endtask

    initial begin
        wt(20);
        presetn <= 1'b1;
        t_reset;
        t_port;
        t_refuse;
        t_standby;
        t_pattern;
        t_timer;
        conclude;
    end

    initial begin
        #100000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude;
    end
endmodule
`default_nettype wire
